// ==== design/ubc_pkg.sv ====
package ubc_pkg;

  // ==========================================================
  // register offsets
  localparam logic [7:0] OFF_CMD   = 8'h00;
  localparam logic [7:0] OFF_MODE  = 8'h04;
  localparam logic [7:0] OFF_STAT  = 8'h08;
  localparam logic [7:0] OFF_RXBUF = 8'h0C;
  localparam logic [7:0] OFF_TXBUF = 8'h10;
  localparam logic [7:0] OFF_ICS   = 8'h14;
  localparam logic [7:0] OFF_AIC   = 8'h18;
  localparam logic [7:0] OFF_ISR   = 8'h1C;
  localparam logic [7:0] OFF_IMR   = 8'h20;

  // ==========================================================
  // fields and codes
  localparam int RC_LSB   = 0;
  localparam int TC_LSB   = 2;
  localparam int PM_LSB   = 3;
  localparam int LOOP_BIT = 7;
  localparam logic [1:0] CMD_NONE    = 2'h0;
  localparam logic [1:0] CMD_ENABLE  = 2'h1;
  localparam logic [1:0] CMD_DISABLE = 2'h2;
  localparam logic [1:0] PM_MULTIDROP = 2'h3;
  localparam int ICS_COS_BIT = 4;
  localparam int ICS_CTS_BIT = 0;
  localparam int AIC_IEC_BIT = 0;
  localparam int ISR_COS_BIT = 7;
  localparam int ISR_RX_BIT  = 1;
  localparam int ISR_TX_BIT  = 0;
  localparam logic [7:0] ISR_W1C_MASK = 8'h83;

  // ==========================================================
  // reset values
  localparam logic [7:0] MODE_RST = 8'h00;
  localparam logic [7:0] AIC_RST  = 8'h00;
  localparam logic [7:0] IMR_RST  = 8'h00;

  // ==========================================================
  // timing
  localparam int CLK_PERIOD_NS = 8;
  localparam int COS_MIN_NS    = 25000;
  localparam int COS_FILT_CYC  = (COS_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int STARTUP_SER_PERIODS = 2;

  // ==========================================================
  // types
  typedef struct packed {
    logic       wr;
    logic [7:0] addr;
  } ubc_req_s;

  typedef enum logic [3:0] {
    RX_SEARCH = 4'h1,
    RX_START  = 4'h2,
    RX_DATA   = 4'h4,
    RX_STOP   = 4'h8
  } ubc_rx_e;

  typedef enum logic [1:0] {
    TX_IDLE  = 2'h1,
    TX_SHIFT = 2'h2
  } ubc_tx_e;

endpackage

// ==== design/ubc_top.sv ====
`timescale 1ns/100ps
module ubc_top #(
  parameter int BIT_CYC  = 16,
  parameter int RX_DEPTH = 3
) (
  input  wire logic        ref_clk,
  input  wire logic        rst_n,
  input  wire logic        ce,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  output logic             irq,
  output logic             txd,
  input  wire logic        rxd_pin,
  input  wire logic        cts_n_pin
);

  localparam int BW = $clog2(BIT_CYC);
  localparam int PW = $clog2(RX_DEPTH);
  localparam int CW = $clog2(RX_DEPTH + 1);
  localparam int FW = $clog2(ubc_pkg::COS_FILT_CYC + 1);
  localparam int START_CYC = ubc_pkg::STARTUP_SER_PERIODS * BIT_CYC;
  localparam int SW = $clog2(START_CYC + 1);

  // ==========================================================
  // end counts, cut to the width of the counter they meet
  localparam logic [BW-1:0] BIT_END   = BW'(BIT_CYC - 1);
  localparam logic [BW-1:0] HALF_END  = BW'(BIT_CYC / 2 - 1);
  localparam logic [FW-1:0] FILT_END  = FW'(ubc_pkg::COS_FILT_CYC - 1);
  localparam logic [SW-1:0] START_END = SW'(START_CYC - 1);
  localparam logic [CW-1:0] DEPTH_C   = CW'(RX_DEPTH);
  localparam logic [PW-1:0] PTR_END   = PW'(RX_DEPTH - 1);

  // ==========================================================
  // bus slave: address phase capture and decode
  ubc_pkg::ubc_req_s dp;
  logic              dp_vld;
  logic [7:0]        mode;
  logic [7:0]        aic;
  logic [7:0]        imr;
  logic [7:0]        isr;
  logic              isr_cos;
  logic              rx_en;
  logic              tx_en;
  logic              tx_rdy;
  logic              th_full;
  logic [7:0]        th;
  logic              cts_state;
  logic              ic_cos;
  logic [CW-1:0]     cnt;
  logic [PW-1:0]     rd_ptr;
  logic [PW-1:0]     wr_ptr;
  logic [7:0]        fifo [RX_DEPTH];

  // ==========================================================
  // pin synchronisers and serial state
  logic [1:0]          rxd_sync;
  logic [1:0]          cts_sync;
  logic                rxd_s;
  logic                cts_s;
  ubc_pkg::ubc_rx_e    rx_st;
  ubc_pkg::ubc_rx_e    next_rx_st;
  logic [BW-1:0]       rx_tmr;
  logic [BW-1:0]       next_rx_tmr;
  logic [2:0]          rx_idx;
  logic [2:0]          next_rx_idx;
  logic [7:0]          rx_sh;
  logic [7:0]          next_rx_sh;
  logic                rx_done;
  ubc_pkg::ubc_tx_e    tx_st;
  ubc_pkg::ubc_tx_e    next_tx_st;
  logic [BW-1:0]       tx_tmr;
  logic [BW-1:0]       next_tx_tmr;
  logic [3:0]          tx_idx;
  logic [3:0]          next_tx_idx;
  logic [8:0]          tx_sh;
  logic [8:0]          next_tx_sh;
  logic                next_txd;
  logic [SW-1:0]       st_cnt;
  logic                st_done;
  logic [FW-1:0]       flt;

  // ==========================================================
  // decode wires
  logic       addr_ok;
  logic       wr_fire;
  logic       rd_fire;
  logic       wr_cmd;
  logic       wr_mode;
  logic       wr_txbuf;
  logic       wr_aic;
  logic       wr_isr;
  logic       wr_imr;
  logic       rd_rxbuf;
  logic       rd_ics;
  logic [1:0] rc_code;
  logic [1:0] tc_code;
  logic [1:0] pm;
  logic       loop_on;
  logic       rx_keep;
  logic       rx_run;
  logic       cmd_rx_on;
  logic       cmd_rx_off;
  logic       cmd_tx_on;
  logic       cmd_tx_off;
  logic       rx_ready;
  logic       fifo_full;
  logic       pop;
  logic       push;
  logic       tx_take;
  logic       tx_load;
  logic       cos_evt;
  logic       cos_w1c;
  logic [7:0] stat;
  logic [7:0] ics;
  logic [7:0] rd_mux;

  assign rxd_s    = rxd_sync[1];
  assign cts_s    = cts_sync[1];
  assign addr_ok  = hsel && htrans[1] && hready;
  assign wr_fire  = dp_vld && dp.wr;
  assign rd_fire  = dp_vld && !dp.wr;
  assign wr_cmd   = wr_fire && (dp.addr == ubc_pkg::OFF_CMD);
  assign wr_mode  = wr_fire && (dp.addr == ubc_pkg::OFF_MODE);
  assign wr_txbuf = wr_fire && (dp.addr == ubc_pkg::OFF_TXBUF);
  assign wr_aic   = wr_fire && (dp.addr == ubc_pkg::OFF_AIC);
  assign wr_isr   = wr_fire && (dp.addr == ubc_pkg::OFF_ISR);
  assign wr_imr   = wr_fire && (dp.addr == ubc_pkg::OFF_IMR);
  assign rd_rxbuf = rd_fire && (dp.addr == ubc_pkg::OFF_RXBUF);
  assign rd_ics   = rd_fire && (dp.addr == ubc_pkg::OFF_ICS);
  assign rc_code  = hwdata[ubc_pkg::RC_LSB +: 2];
  assign tc_code  = hwdata[ubc_pkg::TC_LSB +: 2];
  assign pm       = mode[ubc_pkg::PM_LSB +: 2];
  assign loop_on  = mode[ubc_pkg::LOOP_BIT];

  assign rx_keep    = loop_on || (pm == ubc_pkg::PM_MULTIDROP);
  assign rx_run     = rx_en || rx_keep;
  // receiver and transmitter commands; code 00 and reserved 11 decode to nothing
  assign cmd_rx_on  = wr_cmd && (rc_code == ubc_pkg::CMD_ENABLE) && (pm != ubc_pkg::PM_MULTIDROP);
  assign cmd_rx_off = wr_cmd && (rc_code == ubc_pkg::CMD_DISABLE);
  assign cmd_tx_on  = wr_cmd && (tc_code == ubc_pkg::CMD_ENABLE);
  assign cmd_tx_off = wr_cmd && (tc_code == ubc_pkg::CMD_DISABLE);

  assign rx_ready  = (cnt != '0);
  assign fifo_full = (cnt == DEPTH_C);
  assign pop       = rd_rxbuf && rx_ready;
  // overrun: a full queue drops the new character unless a read frees a slot
  assign push      = rx_done && (!fifo_full || pop);

  // holding register takes only when ready and enabled
  assign tx_take = wr_txbuf && tx_rdy && tx_en;
  assign tx_load = (tx_st == ubc_pkg::TX_IDLE) && th_full && tx_en;

  assign cos_evt = st_done ? ((cts_s != cts_state) && (flt == FILT_END))
                           : ((st_cnt == START_END) && !cts_s);
  assign cos_w1c = wr_isr && hwdata[ubc_pkg::ISR_COS_BIT];

  assign isr  = {isr_cos, 5'h00, rx_ready, tx_rdy};
  assign stat = {5'h00, tx_rdy, fifo_full, rx_ready};
  // bit 0 is the pin level, so asserted reads 0
  assign ics  = {3'h0, ic_cos, 3'h0, cts_state};

  assign rd_mux = (dp.addr == ubc_pkg::OFF_MODE)  ? mode :
                  (dp.addr == ubc_pkg::OFF_STAT)  ? stat :
                  (dp.addr == ubc_pkg::OFF_RXBUF) ? (rx_ready ? fifo[rd_ptr] : 8'h00) :
                  (dp.addr == ubc_pkg::OFF_ICS)   ? ics :
                  (dp.addr == ubc_pkg::OFF_AIC)   ? aic :
                  (dp.addr == ubc_pkg::OFF_ISR)   ? isr :
                  (dp.addr == ubc_pkg::OFF_IMR)   ? imr :
                  8'h00;

  // ==========================================================
  // bus timing: writes finish in one data cycle, reads add one wait state
  // so that read data leaves a flop and read side effects fire once
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      dp        <= '0;
      dp_vld    <= 1'b0;
      hreadyout <= 1'b1;
      hrdata    <= 32'h0000_0000;
      hresp     <= 1'b0;
    end else if (ce) begin
      hresp  <= 1'b0;
      dp_vld <= addr_ok;
      if (addr_ok) begin
        dp.wr     <= hwrite;
        dp.addr   <= haddr[7:0];
        hreadyout <= hwrite;
      end
      if (rd_fire) begin
        hrdata    <= {24'h00_0000, rd_mux};
        hreadyout <= 1'b1;
      end
    end
  end

  // ==========================================================
  // software registers
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      mode <= ubc_pkg::MODE_RST;
      aic  <= ubc_pkg::AIC_RST;
      imr  <= ubc_pkg::IMR_RST;
    end else if (ce) begin
      if (wr_mode) begin
        mode <= hwdata[7:0];
      end
      if (wr_aic) begin
        aic <= {7'h00, hwdata[ubc_pkg::AIC_IEC_BIT]};
      end
      if (wr_imr) begin
        imr <= hwdata[7:0];
      end
    end
  end

  // ==========================================================
  // pin synchronisers
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rxd_sync <= 2'h3;
      cts_sync <= 2'h3;
    end else if (ce) begin
      rxd_sync <= {rxd_sync[0], rxd_pin};
      cts_sync <= {cts_sync[0], cts_n_pin};
    end
  end

  // ==========================================================
  // receiver enable
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_en <= 1'b0;
    end else if (ce) begin
      if (cmd_rx_off) begin
        rx_en <= 1'b0;
      end else if (cmd_rx_on) begin
        rx_en <= 1'b1;
      end
    end
  end

  // ==========================================================
  // receive shifter, sampling mid-bit
  always_comb begin
    next_rx_st  = rx_st;
    next_rx_tmr = rx_tmr + 1'b1;
    next_rx_idx = rx_idx;
    next_rx_sh  = rx_sh;
    rx_done     = 1'b0;
    unique case (rx_st)
      ubc_pkg::RX_SEARCH: begin
        next_rx_tmr = '0;
        if (!rxd_s) begin
          next_rx_st = ubc_pkg::RX_START;
        end
      end
      ubc_pkg::RX_START: begin
        if (rx_tmr == HALF_END) begin
          next_rx_tmr = '0;
          next_rx_idx = '0;
          // a start bit gone by mid-bit was a glitch
          next_rx_st  = rxd_s ? ubc_pkg::RX_SEARCH : ubc_pkg::RX_DATA;
        end
      end
      ubc_pkg::RX_DATA: begin
        if (rx_tmr == BIT_END) begin
          next_rx_tmr = '0;
          next_rx_sh  = {rxd_s, rx_sh[7:1]};
          next_rx_idx = rx_idx + 1'b1;
          if (rx_idx == 3'h7) begin
            next_rx_st = ubc_pkg::RX_STOP;
          end
        end
      end
      ubc_pkg::RX_STOP: begin
        if (rx_tmr == BIT_END) begin
          rx_done    = rxd_s;
          next_rx_st = ubc_pkg::RX_SEARCH;
        end
      end
      default: begin
        next_rx_st = ubc_pkg::RX_SEARCH;
      end
    endcase
    // stopped receiver waits in search, partial character lost
    if (!rx_run) begin
      next_rx_st = ubc_pkg::RX_SEARCH;
      rx_done    = 1'b0;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_st  <= ubc_pkg::RX_SEARCH;
      rx_tmr <= '0;
      rx_idx <= '0;
      rx_sh  <= 8'h00;
    end else if (ce) begin
      rx_st  <= next_rx_st;
      rx_tmr <= next_rx_tmr;
      rx_idx <= next_rx_idx;
      rx_sh  <= next_rx_sh;
    end
  end

  // ==========================================================
  // three-entry receive queue
  always_ff @(posedge ref_clk) begin
    if (ce && push) begin
      fifo[wr_ptr] <= rx_sh;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt    <= '0;
      rd_ptr <= '0;
      wr_ptr <= '0;
    end else if (ce) begin
      // append at the bottom, read from the top
      if (push) begin
        wr_ptr <= (wr_ptr == PTR_END) ? '0 : wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= (rd_ptr == PTR_END) ? '0 : rd_ptr + 1'b1;
      end
      if (push && !pop) begin
        cnt <= cnt + 1'b1;
      end else if (pop && !push) begin
        cnt <= cnt - 1'b1;
      end
    end
  end

  // ==========================================================
  // transmit holding register and ready flag
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_en   <= 1'b0;
      tx_rdy  <= 1'b0;
      th_full <= 1'b0;
      th      <= 8'h00;
    end else if (ce) begin
      if (cmd_tx_off) begin
        tx_en   <= 1'b0;
        tx_rdy  <= 1'b0;
        th_full <= 1'b0;
      end else if (cmd_tx_on && !tx_en) begin
        tx_en  <= 1'b1;
        tx_rdy <= 1'b1;
      end else if (tx_take) begin
        th      <= hwdata[7:0];
        th_full <= 1'b1;
        tx_rdy  <= 1'b0;
      end else if (tx_load) begin
        th_full <= 1'b0;
        tx_rdy  <= 1'b1;
      end
    end
  end

  // ==========================================================
  // transmit shifter; a disable lets the running character finish
  always_comb begin
    next_tx_st  = tx_st;
    next_tx_tmr = tx_tmr + 1'b1;
    next_tx_idx = tx_idx;
    next_tx_sh  = tx_sh;
    next_txd    = txd;
    unique case (tx_st)
      ubc_pkg::TX_IDLE: begin
        next_tx_tmr = '0;
        next_tx_idx = '0;
        if (tx_load) begin
          next_tx_st = ubc_pkg::TX_SHIFT;
          next_tx_sh = {1'b1, th};
          next_txd   = 1'b0;
        end
      end
      ubc_pkg::TX_SHIFT: begin
        if (tx_tmr == BIT_END) begin
          next_tx_tmr = '0;
          if (tx_idx == 4'h9) begin
            next_tx_st = ubc_pkg::TX_IDLE;
            next_txd   = 1'b1;
          end else begin
            next_txd    = tx_sh[0];
            next_tx_sh  = {1'b1, tx_sh[8:1]};
            next_tx_idx = tx_idx + 1'b1;
          end
        end
      end
      default: begin
        next_tx_st = ubc_pkg::TX_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_st  <= ubc_pkg::TX_IDLE;
      tx_tmr <= '0;
      tx_idx <= '0;
      tx_sh  <= 9'h1FF;
      txd    <= 1'b1;
    end else if (ce) begin
      tx_st  <= next_tx_st;
      tx_tmr <= next_tx_tmr;
      tx_idx <= next_tx_idx;
      tx_sh  <= next_tx_sh;
      txd    <= next_txd;
    end
  end

  // ==========================================================
  // clear-to-send startup and glitch filter
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_cnt    <= '0;
      st_done   <= 1'b0;
      flt       <= '0;
      cts_state <= 1'b1;
    end else if (ce) begin
      if (!st_done) begin
        // track the pin after two bit periods
        if (st_cnt == START_END) begin
          st_done   <= 1'b1;
          cts_state <= cts_s;
        end else begin
          st_cnt <= st_cnt + 1'b1;
        end
      end else if (cts_s == cts_state) begin
        flt <= '0;
      end else if (flt == FILT_END) begin
        cts_state <= cts_s;
        flt       <= '0;
      end else begin
        flt <= flt + 1'b1;
      end
    end
  end

  // ==========================================================
  // change flags: a new change wins over a clear in the same cycle
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ic_cos  <= 1'b0;
      isr_cos <= 1'b0;
    end else if (ce) begin
      if (cos_evt) begin
        ic_cos <= 1'b1;
      end else if (rd_ics) begin
        ic_cos <= 1'b0;
      end
      if (cos_evt && aic[ubc_pkg::AIC_IEC_BIT]) begin
        isr_cos <= 1'b1;
      end else if (rd_ics || cos_w1c) begin
        isr_cos <= 1'b0;
      end
    end
  end

  // ==========================================================
  // masked interrupt output
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      irq <= 1'b0;
    end else if (ce) begin
      irq <= |(isr & imr);
    end
  end

  // ==========================================================
  // assertions
  irq_mask_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    $past(ce) |-> (irq == $past(|(isr & imr))))
    else $error("irq does not follow masked status");

  rx_depth_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    cnt <= DEPTH_C)
    else $error("receive queue count above depth");

  rx_off_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (ce && cmd_rx_off) |=> !rx_en)
    else $error("receiver still enabled after disable");

  rx_on_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (ce && cmd_rx_on && !cmd_rx_off) |=> rx_en)
    else $error("receiver not enabled by command");

  tx_take_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (ce && tx_take && !cmd_tx_off && !cmd_tx_on) |=> (!tx_rdy && th_full))
    else $error("accepted character did not clear ready");

  tx_block_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (ce && wr_txbuf && !tx_take) |=> $stable(th))
    else $error("refused write changed holding register");

  cos_gate_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (ce && !aic[ubc_pkg::AIC_IEC_BIT] && !isr_cos) |=> !isr_cos)
    else $error("change flag set with input enable off");

  ics_clear_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (ce && rd_ics && !cos_evt) |=> !isr_cos)
    else $error("change flag kept after register read");

endmodule

// ==== sim/ubc_remote.sv ====
`timescale 1ns/100ps
module ubc_remote #(
  parameter int BIT_CYC = 16
) (
  input  wire logic ref_clk,
  output logic      rxd
);
  initial rxd = 1'b1;
  // ==========
  // one 8N1 character, lsb first; line idles high between frames
  task automatic send(input logic [7:0] c);
    logic [9:0] f;
    f = {1'b1, c, 1'b0};
    for (int i = 0; i < 10; i++) begin
      rxd <= f[i];
      repeat (BIT_CYC) @(posedge ref_clk);
    end
  endtask
endmodule

// ==== sim/ubc_top_bench.sv ====
`timescale 1ns/100ps
module ubc_top_bench;
  logic        ref_clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        hwrite = 1'b0;
  logic        ce = 1'b1;
  logic        hsel = 1'b1;
  logic [2:0]  hsize = 3'h2;
  logic        txd;
  logic        cts_n = 1'b1;
  logic [1:0]  htrans = 2'h0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata, q;
  logic        hrdy, irq, rxd;
  int          num_errors = 0;
  int          samples_checked = 0;
  int          cyc = 0;
  ubc_top dut (.ref_clk, .rst_n, .ce, .hsel, .haddr, .htrans, .hwrite,
    .hsize, .hwdata, .hready(hrdy), .hrdata, .hreadyout(hrdy), .hresp(), .irq,
    .txd, .rxd_pin(rxd), .cts_n_pin(cts_n));
  ubc_remote r (.ref_clk, .rxd);
  initial forever #4 ref_clk = ~ref_clk;
  always @(posedge ref_clk) if (++cyc == 20000) begin
    num_errors++;
    end_sim();
  end
  task automatic end_sim();
    $display("errors %0d checks %0d", num_errors, samples_checked);
    if (num_errors == 0 && samples_checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] s, e);
    samples_checked++;
    if (s !== e) begin
      num_errors++;
      $display("mismatch %s exp %h seen %h", n, e, s);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    haddr <= {24'h0, a};
    hwrite <= w;
    htrans <= 2'h2;
    do @(posedge ref_clk); while (hrdy !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge ref_clk); while (hrdy !== 1'b1);
    q = hrdata;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] m, e);
    bus(1'b0, a, 32'h0);
    chk("hrdata", q & m, e);
  endtask
  initial begin
    repeat (2) @(posedge ref_clk);
    rst_n <= 1'b1;
    repeat (200) @(posedge ref_clk);
    rd(ubc_pkg::OFF_AIC, 32'hFF, 32'(ubc_pkg::AIC_RST));
    rd(ubc_pkg::OFF_IMR, 32'hFF, 32'(ubc_pkg::IMR_RST));
    rd(ubc_pkg::OFF_ICS, 32'h11, 32'h1);
    $display("test reset done");
    bus(1'b1, ubc_pkg::OFF_CMD, 32'h1);
    r.send(8'hA5);
    r.send(8'h3C);
    rd(ubc_pkg::OFF_ISR, 32'h2, 32'h2);
    rd(ubc_pkg::OFF_RXBUF, 32'hFF, 32'hA5);
    rd(ubc_pkg::OFF_RXBUF, 32'hFF, 32'h3C);
    rd(ubc_pkg::OFF_ISR, 32'h2, 32'h0);
    bus(1'b1, ubc_pkg::OFF_CMD, 32'h2);
    r.send(8'h5A);
    rd(ubc_pkg::OFF_ISR, 32'h2, 32'h0);
    $display("test rx done");
    bus(1'b1, ubc_pkg::OFF_AIC, 32'h1);
    bus(1'b1, ubc_pkg::OFF_IMR, 32'h80);
    cts_n <= 1'b0;
    repeat (ubc_pkg::COS_FILT_CYC * 2 + 100) @(posedge ref_clk);
    chk("irq", {31'h0, irq}, 32'h1);
    rd(ubc_pkg::OFF_ICS, 32'h11, 32'h10);
    repeat (2) @(posedge ref_clk);
    chk("irq", {31'h0, irq}, 32'h0);
    $display("test cos done");
    bus(1'b1, ubc_pkg::OFF_CMD, 32'h4);
    bus(1'b1, ubc_pkg::OFF_TXBUF, 32'h55);
    repeat (3) @(posedge ref_clk);
    chk("txd", {31'h0, txd}, 32'h0);
    rd(ubc_pkg::OFF_ISR, 32'h1, 32'h1);
    $display("test tx done");
    ce <= 1'b0;
    bus(1'b1, ubc_pkg::OFF_IMR, 32'hFF);
    ce <= 1'b1;
    rd(ubc_pkg::OFF_IMR, 32'hFF, 32'h80);
    $display("test freeze done");
    end_sim();
  end
endmodule
